/* verification/gswoc_hash_model.sv */
// keyed hash engine stand-in that answers the latest start pulse after a delay
`timescale 1ns/10ps
`default_nettype none
module gswoc_hash_model import gswoc_pkg::*; #(
  parameter logic [DATA_W-1:0] KEY_WORD = 32'h5A3C96E1,
  parameter int DELAY = 12
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // hash request and answer
  input wire logic start_i,
  input wire logic [AUTH_BITS-1:0] challenge_i,
  output logic done_o,
  output logic [AUTH_BITS-1:0] digest_o
);
  int cnt;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 0;
      done_o <= 1'b0;
      digest_o <= '0;
    end else begin
      // digest only valid with done, garbage otherwise
      done_o <= (cnt == 1);
      digest_o <= (cnt == 1) ? challenge_i ^ {AUTH_WORDS{KEY_WORD}} : ~digest_o;
      if (start_i) begin
        cnt <= DELAY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : gswoc_hash_model
`default_nettype wire

/* verification/gswoc_tb.sv */
// self-checking bench for the sleep-wake and offset-calibration block
`timescale 1ns/10ps
`default_nettype none
module gswoc_tb import gswoc_pkg::*;;
  localparam logic [31:0] KEY = 32'h5A3C96E1;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, sv = 0, sreq = 0, rd_d = 0, sv_d = 0, ce = 1;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0, rdata;
  logic signed [15:0] raw = '0, curr = 16'sh01F4, cur = '0, off = '0, cur_o;
  logic [15:0] volt = 16'h0BB8;
  logic signed [7:0] temp = 8'sh19;
  logic signed [31:0] acc;
  logic irq, cal, fprog, sres, hstart, hdone;
  logic [1:0] mode, stype;
  logic [159:0] chal, dig;
  logic [31:0] rq[$], sq[$], ch[5];
  int bad_count = 0, num_checks = 0, seed = 17, fp_cnt = 0, sgn;
  int th[8] = '{0, 10, 22, 46, 0, 22, 46, 98};
  always #50 clk = ~clk;
  gswoc_top #(.TEMP_HOLD_CYC(20), .CAL_LOG(2)) dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .CE_I(ce),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq),
    .SAMPLE_VALID_I(sv), .SENSE_RAW_I(raw), .VOLTAGE_I(volt), .TEMP_I(temp), .AVG_CURR_I(curr),
    .SLEEP_REQ_I(sreq), .CURRENT_O(cur_o), .CHARGE_ACC_O(acc), .CAL_ACTIVE_O(cal),
    .POWER_MODE_O(mode), .FLASH_PROG_O(fprog), .SOFT_RESET_O(sres), .SOFT_RESET_TYPE_O(stype),
    .HASH_START_O(hstart), .CHALLENGE_O(chal), .HASH_DONE_I(hdone), .DIGEST_I(dig));
  gswoc_hash_model #(.KEY_WORD(KEY)) u_hash (.clk_i(clk), .rstn_i(rstn), .start_i(hstart),
    .challenge_i(chal), .done_o(hdone), .digest_o(dig));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    rq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic smp(input logic signed [15:0] r, input logic held);
    @(posedge clk);
    sv <= 1'b1;
    raw <= r;
    if (!held) begin
      cur = r - off;
    end
    sq.push_back({16'h0000, cur});
    @(posedge clk);
    sv <= 1'b0;
  endtask : smp
  task automatic wait_cal(input logic lvl);
    int n;
    n = 0;
    while (cal !== lvl && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n == 300) begin
      bad_count++;
      conclude();
    end
  endtask : wait_cal
  // result watcher: read data and corrected current
  always @(posedge clk) begin
    if (rd_d) begin
      chk(rdata, rq.pop_front());
    end
    if (sv_d) begin
      chk({16'h0000, cur_o}, sq.pop_front());
    end
    rd_d <= rd;
    sv_d <= sv;
    fp_cnt <= fp_cnt + int'(fprog);
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(REG_FLASH_LIM, {16'h0000, FLASH_LIM_RST});
    rd_reg(REG_OFFSET, 32'h0);
    rd_reg(8'h30, 32'h0);
    for (int t = 0; t < 4; t++) begin
      for (int k = 0; k <= t; k++) begin
        wr_reg(REG_CMD, 32'(t * 16 + 1));
      end
    end
    rd_reg(REG_RESET_DATA, 32'h04030201);
    wr_reg(REG_FLASH_LIM, 32'h0BB8);
    wr_reg(REG_FLASH_REQ, 32'h0);
    volt <= 16'h0BB7;
    wr_reg(REG_FLASH_REQ, 32'h0);
    rd_reg(REG_STATUS, 32'h8);
    chk(fp_cnt, 1);
    ce <= 1'b0;
    wr_reg(REG_MASK, 32'h1F);
    ce <= 1'b1;
    rd_reg(REG_MASK, 32'h0);
    volt <= 16'h0BB8;
    repeat (6) smp(16'($random(seed)), 1'b0);
    wr_reg(REG_CMD, {28'h0, OP_SLEEP});
    wait_cal(1'b1);
    repeat (4) smp(16'sd20, 1'b1);
    wait_cal(1'b0);
    off = 16'sd20;
    rd_reg(REG_OFFSET, 32'h14);
    rd_reg(REG_STATUS, 32'h2);
    wr_reg(REG_CFG, 32'h4);
    smp(16'sh7FFF, 1'b0);
    rd_reg(REG_STATUS, 32'h0);
    temp <= 8'sh2D;
    for (int i = 1; i < 8; i++) begin
      if (i != 4) begin
        sgn = (i % 2) ? -1 : 1;
        wr_reg(REG_CFG, 32'(i));
        wr_reg(REG_MASK, 32'(i % 2));
        wr_reg(REG_CMD, {28'h0, (i % 2) ? OP_DEEP : OP_SLEEP});
        smp(16'(sgn * (th[i] - 1)), 1'b0);
        rd_reg(REG_STATUS, 32'h0);
        smp(16'(sgn * th[i]), 1'b0);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'(i % 2));
        chk(32'(mode), 32'h0);
        rd_reg(REG_STATUS, 32'h1);
      end
    end
    wr_reg(REG_CMD, {28'h0, OP_LOWEST});
    @(posedge clk);
    chk(32'(mode), 32'h3);
    wr_reg(REG_CMD, {28'h0, OP_NORMAL});
    sreq <= 1'b1;
    repeat (3) @(posedge clk);
    sreq <= 1'b0;
    chk(32'(mode), 32'h1);
    wr_reg(REG_CMD, {28'h0, OP_NORMAL});
    curr <= 16'sh0032;
    volt <= 16'h0CE4;
    wait_cal(1'b1);
    curr <= 16'sh01F4;
    volt <= 16'h0CC3;
    wait_cal(1'b0);
    rd_reg(REG_STATUS, 32'h4);
    rd_reg(REG_OFFSET, 32'h14);
    curr <= 16'sh0032;
    wait_cal(1'b1);
    repeat (4) smp(16'sd8, 1'b1);
    wait_cal(1'b0);
    off = 16'sd8;
    curr <= 16'sh01F4;
    rd_reg(REG_STATUS, 32'h2);
    rd_reg(REG_OFFSET, 32'h8);
    smp(16'sh0100, 1'b0);
    for (int w = 0; w < 5; w++) begin
      ch[w] = $random(seed);
      wr_reg(REG_CHAL_BASE + 8'(4 * w), ch[w]);
    end
    wr_reg(REG_AUTH_GO, 32'h0);
    repeat (20) @(posedge clk);
    rd_reg(REG_STATUS, 32'h10);
    for (int w = 0; w < 5; w++) begin
      rd_reg(REG_DIG_BASE + 8'(4 * w), ch[w] ^ KEY);
    end
    rd_reg(REG_CHAL_BASE, ch[0]);
    repeat (4) @(posedge clk);
    chk(32'(rq.size() + sq.size()), 32'h0);
    conclude();
  end
  initial begin
    repeat (50000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule : gswoc_tb
`default_nettype wire

/* verification/gswoc_top_asserts.sv */
// concurrent checks on the top ports of the sleep-wake block
`timescale 1ns/10ps
`default_nettype none
module gswoc_top_asserts import gswoc_pkg::*; (
  // clock, enable and reset
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  // register port
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [DATA_W-1:0] RDATA_O,
  // measurement and control
  input wire logic SAMPLE_VALID_I,
  input wire logic signed [SMP_W-1:0] CURRENT_O,
  input wire logic signed [31:0] CHARGE_ACC_O,
  input wire logic CAL_ACTIVE_O,
  input wire logic [1:0] POWER_MODE_O,
  input wire logic FLASH_PROG_O,
  input wire logic SOFT_RESET_O,
  input wire logic [RST_TYPE_W-1:0] SOFT_RESET_TYPE_O,
  input wire logic HASH_START_O
);
  wire logic wr_cmd;
  assign wr_cmd = CE_I && WR_I && ADDR_I == REG_CMD;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  a_rdata_idle: assert property ((CE_I && !RD_I) |=> RDATA_O == '0)
    else $error("read data not zero outside a read");
  a_reset_cause: assert property (SOFT_RESET_O |-> $past(wr_cmd && WDATA_I[3:0] == OP_RESET))
    else $error("soft reset pulse without command");
  a_reset_type: assert property ((wr_cmd && WDATA_I[3:0] == OP_RESET) |=> SOFT_RESET_O && SOFT_RESET_TYPE_O == $past(WDATA_I[5:4]))
    else $error("soft reset type wrong");
  a_flash_cause: assert property (FLASH_PROG_O |-> $past(CE_I && WR_I && ADDR_I == REG_FLASH_REQ))
    else $error("flash program without request");
  a_sleep_cmd: assert property ((wr_cmd && WDATA_I[3:0] == OP_SLEEP) |=> POWER_MODE_O == 2'h1)
    else $error("sleep command not obeyed");
  a_cal_hold: assert property (CAL_ACTIVE_O |=> $stable(CURRENT_O))
    else $error("current changed during calibration");
  a_charge_add: assert property ((CE_I && SAMPLE_VALID_I) |=> CHARGE_ACC_O == $past(CHARGE_ACC_O) + CURRENT_O)
    else $error("charge sum wrong");
  a_charge_idle: assert property (!SAMPLE_VALID_I |=> $stable(CHARGE_ACC_O))
    else $error("charge moved without sample");
  a_cal_start: assert property ($rose(CAL_ACTIVE_O) |-> $past(POWER_MODE_O) != 2'h3)
    else $error("calibration started in lowest power");
  a_hash_cause: assert property (HASH_START_O |-> $past(CE_I && WR_I && ADDR_I == REG_AUTH_GO))
    else $error("hash start without request");
endmodule : gswoc_top_asserts
bind gswoc_top gswoc_top_asserts u_asserts (.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .CE_I(CE_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .SAMPLE_VALID_I(SAMPLE_VALID_I), .CURRENT_O(CURRENT_O), .CHARGE_ACC_O(CHARGE_ACC_O),
  .CAL_ACTIVE_O(CAL_ACTIVE_O), .POWER_MODE_O(POWER_MODE_O), .FLASH_PROG_O(FLASH_PROG_O),
  .SOFT_RESET_O(SOFT_RESET_O), .SOFT_RESET_TYPE_O(SOFT_RESET_TYPE_O), .HASH_START_O(HASH_START_O));
`default_nettype wire

/* verilog/gswoc_pkg.sv */
// constants, register map and types for the sleep-wake and offset-calibration block
package gswoc_pkg;

  // register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_FLASH_LIM = 8'h08;
  localparam logic [7:0] REG_FLASH_REQ = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h14;
  localparam logic [7:0] REG_STATE = 8'h18;
  localparam logic [7:0] REG_OFFSET = 8'h1C;
  localparam logic [7:0] REG_RESET_DATA = 8'h20;
  localparam logic [7:0] REG_AUTH_GO = 8'h24;
  localparam logic [7:0] REG_CHAL_BASE = 8'h40;
  localparam logic [7:0] REG_DIG_BASE = 8'h60;

  // challenge and digest: 160 bits as five words, word 0 holds bits 31:0
  localparam int AUTH_WORDS = 5;
  localparam int AUTH_BITS = AUTH_WORDS * DATA_W;
  localparam int AUTH_IDX_W = 3;
  localparam int AUTH_IDX_LSB = 2;
  localparam int AUTH_REGION_LSB = 5;
  localparam int AUTH_REGION_W = 3;

  // configuration bits
  localparam int CFG_W = 3;
  localparam int CFG_SEL_LO = 0;
  localparam int CFG_SEL_HI = 1;
  localparam int CFG_RANGE = 2;
  localparam logic [CFG_W-1:0] CFG_RST = 3'h0;

  // command register fields and codes
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 4;
  localparam int CMD_TYPE_LSB = 4;
  localparam int RST_TYPE_W = 2;
  localparam logic [CMD_OP_W-1:0] OP_RESET = 4'h1;
  localparam logic [CMD_OP_W-1:0] OP_SLEEP = 4'h2;
  localparam logic [CMD_OP_W-1:0] OP_DEEP = 4'h3;
  localparam logic [CMD_OP_W-1:0] OP_LOWEST = 4'h4;
  localparam logic [CMD_OP_W-1:0] OP_NORMAL = 4'h5;

  // sticky event bits
  localparam int N_EV = 5;
  localparam int EV_WAKE = 0;
  localparam int EV_CAL_DONE = 1;
  localparam int EV_CAL_ABORT = 2;
  localparam int EV_FLASH_REFUSED = 3;
  localparam int EV_DIGEST = 4;

  // state register fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_CAL_BIT = 2;
  localparam int ST_HELD_BIT = 3;

  // reset counters
  localparam int RESET_TYPES = 4;
  localparam int CNT_W = 8;

  // wake thresholds, sense samples in 0.1 mV steps
  localparam int SMP_W = 16;
  localparam logic signed [SMP_W-1:0] WAKE_TH_1MV0 = 16'sh000A;
  localparam logic signed [SMP_W-1:0] WAKE_TH_2MV2 = 16'sh0016;
  localparam logic signed [SMP_W-1:0] WAKE_TH_4MV6 = 16'sh002E;
  localparam logic signed [SMP_W-1:0] WAKE_TH_9MV8 = 16'sh0062;

  // calibration limits: degrees C, mA, mV
  localparam logic signed [7:0] CAL_TEMP_LO = 8'sh05;
  localparam logic signed [7:0] CAL_TEMP_HI = 8'sh2D;
  localparam logic signed [8:0] CAL_TEMP_DELTA = 9'sh008;
  localparam logic [15:0] CAL_CURR_MAX = 16'h0064;
  localparam logic [15:0] CAL_VOLT_DELTA = 16'h0100;
  localparam logic [15:0] CAL_ABORT_DROP = 16'h0020;
  localparam int CAL_SAMPLES_LOG = 2;
  localparam logic [15:0] FLASH_LIM_RST = 16'h0CE4;

  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int TEMP_HOLD_S = 60;
  localparam int TEMP_HOLD_CYCLES = TEMP_HOLD_S * CLK_HZ;

  typedef enum logic [1:0] {PM_NORMAL, PM_SLEEP, PM_DEEP_SLEEP, PM_LOWEST} gswoc_mode_e;
  typedef enum logic {CAL_IDLE, CAL_RUN} gswoc_cal_e;

endpackage : gswoc_pkg

/* verilog/gswoc_top.sv */
// top of the sleep-wake, offset-calibration and housekeeping block
// Functional notes
// - soft reset counts per reset type, readable
// - sleep comparator crossing raises wake event
// - both sense select bits zero disables comparator
// - symmetric thresholds 1.0/2.2/4.6/9.8 mV table
// - flash programming refused below voltage limit
// - sleep entry calibrates unless temperature out of range or entered from lowest power mode
// - low current plus voltage/temperature drift calibrates until one calibration completes
// - during calibration keep last current, keep accumulating
// - voltage drop over 32 mV aborts calibration
// - offset subtracted from every normal sense sample
// - 160-bit challenge in, 160-bit keyed digest out
// - power modes change on events and host commands
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module gswoc_top import gswoc_pkg::*; #(
  parameter int TEMP_HOLD_CYC = TEMP_HOLD_CYCLES,
  parameter int CAL_LOG = CAL_SAMPLES_LOG
) (
  // clock, enable and reset
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  // register port
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [DATA_W-1:0] RDATA_O,
  output logic IRQ_O,
  // measurements
  input wire logic SAMPLE_VALID_I,
  input wire logic signed [SMP_W-1:0] SENSE_RAW_I,
  input wire logic [15:0] VOLTAGE_I,
  input wire logic signed [7:0] TEMP_I,
  input wire logic signed [15:0] AVG_CURR_I,
  input wire logic SLEEP_REQ_I,
  // results and control
  output logic signed [SMP_W-1:0] CURRENT_O,
  output logic signed [31:0] CHARGE_ACC_O,
  output logic CAL_ACTIVE_O,
  output logic [1:0] POWER_MODE_O,
  output logic FLASH_PROG_O,
  output logic SOFT_RESET_O,
  output logic [RST_TYPE_W-1:0] SOFT_RESET_TYPE_O,
  // keyed hash engine
  output logic HASH_START_O,
  output logic [AUTH_BITS-1:0] CHALLENGE_O,
  input wire logic HASH_DONE_I,
  input wire logic [AUTH_BITS-1:0] DIGEST_I
);
  localparam int TW = $clog2(TEMP_HOLD_CYC + 1);
  localparam int SUM_W = SMP_W + CAL_LOG;

  logic [CFG_W-1:0] cfg;
  logic [15:0] flash_lim;
  logic [N_EV-1:0] status;
  logic [N_EV-1:0] mask;
  gswoc_mode_e mode;
  gswoc_cal_e cal_state;
  logic signed [SMP_W-1:0] offset;
  logic signed [SUM_W-1:0] cal_sum;
  logic [CAL_LOG-1:0] cal_cnt;
  logic [15:0] cal_v_start;
  logic [15:0] v_ref;
  logic signed [7:0] t_ref;
  logic [TW-1:0] temp_timer;
  logic [AUTH_BITS-1:0] digest;
  logic [CNT_W-1:0] rst_cnt [RESET_TYPES];
  logic [RESET_TYPES*CNT_W-1:0] rst_pack;
  logic wake_evt;
  gswoc_mode_e next_mode;

  // address decode
  wire wr_cfg = WR_I & (ADDR_I == REG_CFG);
  wire wr_cmd = WR_I & (ADDR_I == REG_CMD);
  wire wr_lim = WR_I & (ADDR_I == REG_FLASH_LIM);
  wire wr_flash = WR_I & (ADDR_I == REG_FLASH_REQ);
  wire wr_mask = WR_I & (ADDR_I == REG_MASK);
  wire wr_auth = WR_I & (ADDR_I == REG_AUTH_GO);
  wire rd_status = RD_I & (ADDR_I == REG_STATUS);
  wire [AUTH_IDX_W-1:0] auth_idx = ADDR_I[AUTH_IDX_LSB +: AUTH_IDX_W];
  wire addr_aligned = (ADDR_I[AUTH_IDX_LSB-1:0] == '0);
  wire auth_idx_ok = (auth_idx < AUTH_IDX_W'(AUTH_WORDS)) & addr_aligned;
  wire [AUTH_REGION_W-1:0] region = ADDR_I[AUTH_REGION_LSB +: AUTH_REGION_W];
  wire in_chal = (region == REG_CHAL_BASE[AUTH_REGION_LSB +: AUTH_REGION_W]) & auth_idx_ok;
  wire in_dig = (region == REG_DIG_BASE[AUTH_REGION_LSB +: AUTH_REGION_W]) & auth_idx_ok;
  wire [ADDR_W-1:0] word_off = {ADDR_I[ADDR_W-1:AUTH_REGION_LSB], {AUTH_REGION_LSB{1'b0}}};

  // read hits
  wire hit_cfg = (ADDR_I == REG_CFG);
  wire hit_lim = (ADDR_I == REG_FLASH_LIM);
  wire hit_status = (ADDR_I == REG_STATUS);
  wire hit_mask = (ADDR_I == REG_MASK);
  wire hit_state = (ADDR_I == REG_STATE);
  wire hit_offset = (ADDR_I == REG_OFFSET);
  wire hit_rst = (ADDR_I == REG_RESET_DATA);
  wire hit_chal = in_chal & (word_off == REG_CHAL_BASE);
  wire hit_dig = in_dig & (word_off == REG_DIG_BASE);

  // host commands
  wire [CMD_OP_W-1:0] cmd_op = WDATA_I[CMD_OP_LSB +: CMD_OP_W];
  wire [RST_TYPE_W-1:0] cmd_type = WDATA_I[CMD_TYPE_LSB +: RST_TYPE_W];
  wire cmd_reset = wr_cmd & (cmd_op == OP_RESET);
  wire cmd_sleep = wr_cmd & (cmd_op == OP_SLEEP);
  wire cmd_deep = wr_cmd & (cmd_op == OP_DEEP);
  wire cmd_lowest = wr_cmd & (cmd_op == OP_LOWEST);
  wire cmd_normal = wr_cmd & (cmd_op == OP_NORMAL);

  wire cmp_enable = (mode == PM_SLEEP) || (mode == PM_DEEP_SLEEP);
  gswoc_wake_cmp u_wake (
    .clk_i(CORE_CLK_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .enable_i(cmp_enable),
    .sense_select_hi_i(cfg[CFG_SEL_HI]),
    .sense_select_lo_i(cfg[CFG_SEL_LO]),
    .wake_range_sel_i(cfg[CFG_RANGE]),
    .sample_valid_i(SAMPLE_VALID_I),
    .sample_i(SENSE_RAW_I),
    .wake_o(wake_evt)
  );

  // power mode moves: internal events first, then host commands override
  always_comb begin
    next_mode = mode;
    unique case (mode)
      PM_NORMAL: if (SLEEP_REQ_I) next_mode = PM_SLEEP;
      PM_SLEEP, PM_DEEP_SLEEP: if (wake_evt) next_mode = PM_NORMAL;
      PM_LOWEST: next_mode = PM_LOWEST;
    endcase
    if (cmd_sleep) next_mode = PM_SLEEP;
    if (cmd_deep) next_mode = PM_DEEP_SLEEP;
    if (cmd_lowest) next_mode = PM_LOWEST;
    if (cmd_normal) next_mode = PM_NORMAL;
  end
  wire sleep_entry = (next_mode == PM_SLEEP) && (mode != PM_SLEEP);

  // calibration triggers
  wire temp_ok = (TEMP_I > CAL_TEMP_LO) && (TEMP_I < CAL_TEMP_HI);
  wire [15:0] curr_mag = AVG_CURR_I[15] ? 16'(-AVG_CURR_I) : AVG_CURR_I;
  wire curr_low = (curr_mag <= CAL_CURR_MAX);
  wire [15:0] v_delta = (VOLTAGE_I >= v_ref) ? VOLTAGE_I - v_ref : v_ref - VOLTAGE_I;
  wire signed [8:0] t_diff = 9'({TEMP_I[7], TEMP_I} - {t_ref[7], t_ref});
  wire t_big = (t_diff > CAL_TEMP_DELTA) || (t_diff < -CAL_TEMP_DELTA);
  wire temp_held = (temp_timer >= TW'(TEMP_HOLD_CYC));
  wire cal_idle = (cal_state == CAL_IDLE);
  wire cal_run = (cal_state == CAL_RUN);
  wire drift_trig = curr_low & ((v_delta >= CAL_VOLT_DELTA) | temp_held);
  wire sleep_trig = sleep_entry & temp_ok;
  wire cal_start = cal_idle & (sleep_trig | drift_trig) & (mode != PM_LOWEST);
  wire v_drop = (cal_v_start > VOLTAGE_I) && ((cal_v_start - VOLTAGE_I) > CAL_ABORT_DROP);
  wire cal_abort = cal_run & v_drop;
  wire signed [SUM_W-1:0] sum_next = cal_sum + SUM_W'(SENSE_RAW_I);
  wire cal_done = cal_run & ~v_drop & SAMPLE_VALID_I & (&cal_cnt);
  gswoc_cal_e next_cal;
  assign next_cal = cal_start ? CAL_RUN : (cal_abort | cal_done) ? CAL_IDLE : cal_state;

  // measurement path
  wire signed [SMP_W-1:0] corrected = SMP_W'(SENSE_RAW_I - offset);
  wire signed [SMP_W-1:0] next_current = cal_run ? CURRENT_O : corrected;
  wire signed [31:0] next_charge = CHARGE_ACC_O + 32'(next_current);

  // flash guard
  wire flash_ok = (VOLTAGE_I >= flash_lim);
  wire flash_refused = wr_flash & ~flash_ok;

  // events and interrupt
  wire [N_EV-1:0] events;
  assign events[EV_WAKE] = wake_evt;
  assign events[EV_CAL_DONE] = cal_done;
  assign events[EV_CAL_ABORT] = cal_abort;
  assign events[EV_FLASH_REFUSED] = flash_refused;
  assign events[EV_DIGEST] = HASH_DONE_I;
  wire [N_EV-1:0] next_status = (status & ~{N_EV{rd_status}}) | events;
  wire [N_EV-1:0] next_mask = wr_mask ? WDATA_I[N_EV-1:0] : mask;

  // read selection
  wire [DATA_W-1:0] state_word = DATA_W'({temp_held, cal_run, mode});
  wire [DATA_W-1:0] offset_word = DATA_W'($unsigned(offset));
  wire [DATA_W-1:0] chal_word = DATA_W'(CHALLENGE_O >> (DATA_W * auth_idx));
  wire [DATA_W-1:0] dig_word = DATA_W'(digest >> (DATA_W * auth_idx));
  wire [DATA_W-1:0] rd_mux =
    hit_cfg ? DATA_W'(cfg) :
    hit_lim ? DATA_W'(flash_lim) :
    hit_status ? DATA_W'(status) :
    hit_mask ? DATA_W'(mask) :
    hit_state ? state_word :
    hit_offset ? offset_word :
    hit_rst ? DATA_W'(rst_pack) :
    hit_chal ? chal_word :
    hit_dig ? dig_word : '0;
  wire wr_chal = WR_I & hit_chal;

  // per-type reset counters
  genvar g;
  generate
    for (g = 0; g < RESET_TYPES; g++) begin : g_rst
      assign rst_pack[g*CNT_W +: CNT_W] = rst_cnt[g];
      always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
          rst_cnt[g] <= '0;
        end else if (CE_I && cmd_reset && cmd_type == RST_TYPE_W'(g) && ~&rst_cnt[g]) begin
          rst_cnt[g] <= rst_cnt[g] + 1'b1;
        end
      end
    end
    for (g = 0; g < AUTH_WORDS; g++) begin : g_chal
      always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
          CHALLENGE_O[g*DATA_W +: DATA_W] <= '0;
        end else if (CE_I && wr_chal && auth_idx == AUTH_IDX_W'(g)) begin
          CHALLENGE_O[g*DATA_W +: DATA_W] <= WDATA_I;
        end
      end
    end
  endgenerate

  // register port and housekeeping
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cfg <= CFG_RST;
      flash_lim <= FLASH_LIM_RST;
      status <= '0;
      mask <= '0;
      IRQ_O <= 1'b0;
      RDATA_O <= '0;
      FLASH_PROG_O <= 1'b0;
      SOFT_RESET_O <= 1'b0;
      SOFT_RESET_TYPE_O <= '0;
      HASH_START_O <= 1'b0;
      digest <= '0;
    end else if (CE_I) begin
      if (wr_cfg) cfg <= WDATA_I[CFG_W-1:0];
      if (wr_lim) flash_lim <= WDATA_I[15:0];
      status <= next_status;
      mask <= next_mask;
      IRQ_O <= |(next_status & next_mask);
      RDATA_O <= RD_I ? rd_mux : '0;
      FLASH_PROG_O <= wr_flash & flash_ok;
      SOFT_RESET_O <= cmd_reset;
      if (cmd_reset) SOFT_RESET_TYPE_O <= cmd_type;
      HASH_START_O <= wr_auth;
      if (HASH_DONE_I) digest <= DIGEST_I;
    end
  end

  // power mode, calibration and drift timer
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mode <= PM_NORMAL;
      POWER_MODE_O <= PM_NORMAL;
      cal_state <= CAL_IDLE;
      CAL_ACTIVE_O <= 1'b0;
      cal_sum <= '0;
      cal_cnt <= '0;
      cal_v_start <= '0;
      offset <= '0;
      v_ref <= '0;
      t_ref <= '0;
      temp_timer <= '0;
    end else if (CE_I) begin
      mode <= next_mode;
      POWER_MODE_O <= next_mode;
      cal_state <= next_cal;
      CAL_ACTIVE_O <= (next_cal == CAL_RUN);
      if (cal_start) begin
        cal_sum <= '0;
        cal_cnt <= '0;
        cal_v_start <= VOLTAGE_I;
      end else if (cal_run && SAMPLE_VALID_I) begin
        cal_sum <= sum_next;
        cal_cnt <= cal_cnt + 1'b1;
      end
      if (cal_done) begin
        offset <= sum_next[CAL_LOG +: SMP_W];
        v_ref <= VOLTAGE_I;
        t_ref <= TEMP_I;
      end
      if (cal_done || !t_big) begin
        temp_timer <= '0;
      end else if (!temp_held) begin
        temp_timer <= temp_timer + 1'b1;
      end
    end
  end

  // measurement registers
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      CURRENT_O <= '0;
      CHARGE_ACC_O <= '0;
    end else if (CE_I && SAMPLE_VALID_I) begin
      CURRENT_O <= next_current;
      CHARGE_ACC_O <= next_charge;
    end
  end

endmodule : gswoc_top
`default_nettype wire

/* verilog/gswoc_wake_cmp.sv */
// sleep wake comparator on the raw sense-resistor sample
`timescale 1ns/10ps
`default_nettype none
module gswoc_wake_cmp import gswoc_pkg::*; (
  // clock, enable and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // control
  input wire logic enable_i,
  input wire logic sense_select_hi_i,
  input wire logic sense_select_lo_i,
  input wire logic wake_range_sel_i,
  // sample
  input wire logic sample_valid_i,
  input wire logic signed [SMP_W-1:0] sample_i,
  // event
  output logic wake_o
);
  wire [2:0] sel = {sense_select_hi_i, sense_select_lo_i, wake_range_sel_i};
  wire logic signed [SMP_W-1:0] th =
    (sel == 3'h2) ? WAKE_TH_1MV0 :
    (sel == 3'h3 || sel == 3'h4) ? WAKE_TH_2MV2 :
    (sel == 3'h5 || sel == 3'h6) ? WAKE_TH_4MV6 : WAKE_TH_9MV8;
  wire armed = enable_i & (sense_select_hi_i | sense_select_lo_i);
  wire crossed = (sample_i >= th) || (sample_i <= -th);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_o <= 1'b0;
    end else if (ce_i) begin
      wake_o <= armed & sample_valid_i & crossed;
    end
  end
endmodule : gswoc_wake_cmp
`default_nettype wire
